// ---- design/uarx_pkg.sv ----
// constants for the oversampling serial receive front end
// assumes a single system clock and a sample tick from an outside divider
package uarx_pkg;
  localparam int          UARX_DATA_BITS   = 8;
  localparam logic [4:0]  UARX_OS_NORMAL   = 5'h10; // samples per bit, normal
  localparam logic [4:0]  UARX_OS_DOUBLE   = 5'h08; // samples per bit, double speed
  localparam logic [4:0]  UARX_VOTE_NORMAL = 5'h08; // first voting sample, normal
  localparam logic [4:0]  UARX_VOTE_DOUBLE = 5'h04; // first voting sample, double speed
  localparam logic [1:0]  UARX_FIFO_DEPTH  = 2'h2;
  localparam logic        UARX_LINE_IDLE   = 1'b1;

  typedef enum logic [1:0] {
    UARX_IDLE  = 2'b00,
    UARX_START = 2'b01,
    UARX_BITS  = 2'b10,
    UARX_STOP  = 2'b11
  } uarx_state_t;
endpackage

// ---- design/uarx_rx.sv ----
// oversampling receiver with start validation, majority voting and two-entry buffer
// assumes sample_tick pulses at 16x (or 8x with double speed) the baud rate
`timescale 1ns/10ps

// Notes on behaviour
// - clearing the receiver enable empties the receive buffer and drops any unread characters.
// - the line is sampled at 16 ticks per bit normally and 8 ticks per bit in double speed.
// - start detection begins on a high to low edge, the first low sample being sample one.
// - start validity uses samples 8, 9 and 10 normally, or 4, 5 and 6 in double speed.
// - if two or more validation samples are high the start is dropped as noise.
// - a valid start realigns the bit timing, and this repeats for every frame.
// - each start and data bit is walked through 16 sample states normally or 8 in double speed; the stop bit ends at its last voting sample.
// - each bit is the majority of its three centre samples.
// - recovery runs through data bits up to the first stop bit, and later stop bits are ignored.
// - a stop bit that votes low sets the frame error flag of that character.
// - a new falling edge is accepted right after the last stop voting sample.
// - the complete flag is high while the buffer holds unread data, registered one clock after the fill count changes.
// - the buffer is a two-entry fifo that advances on each data location read.
module uarx_rx
  import uarx_pkg::*;
#(
  parameter int DATA_BITS = UARX_DATA_BITS
)(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 rx_line,
  input  wire logic                 sample_tick,
  input  wire logic                 receiver_enable_bit,
  input  wire logic                 double_speed_select,
  input  wire logic                 rx_data_rd,
  output logic [DATA_BITS-1:0]      rx_data_location,
  output logic                      rx_complete_flag,
  output logic                      frame_error_flag
);

  // three-sample majority
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  logic                 sync1_r;
  logic                 sync2_r;
  logic                 line_prev_r;
  uarx_state_t          state_r;
  logic [4:0]           samp_r;
  logic [2:0]           vote_r;
  logic [3:0]           bitn_r;
  logic [DATA_BITS-1:0] shift_r;
  logic [DATA_BITS-1:0] mem_d_r [0:1];
  logic                 mem_ferr_r [0:1];
  logic                 rd_ptr_r;
  logic                 wr_ptr_r;
  logic [1:0]           count_r;
  logic [4:0]           per_bit;
  logic [4:0]           vote_lo;
  logic                 last_samp;
  logic                 in_vote;
  logic                 bit_val;
  logic                 push;
  logic                 pop;

  // two-flop synchroniser on the serial input
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sync1_r <= UARX_LINE_IDLE;
      sync2_r <= UARX_LINE_IDLE;
    end
    else
    begin
      sync1_r <= rx_line;
      sync2_r <= sync1_r;
    end
  end

  // line level at the previous sample tick, for falling edge detection;
  // resets to the idle level so that leaving reset gives no false edge, and
  // a low stop bit cannot retrigger a frame while the line stays low
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      line_prev_r <= UARX_LINE_IDLE;
    else if (sample_tick)
      line_prev_r <= sync2_r;
  end

  // sample numbering depends on speed mode
  assign per_bit   = double_speed_select ? UARX_OS_DOUBLE : UARX_OS_NORMAL;
  assign vote_lo   = double_speed_select ? UARX_VOTE_DOUBLE : UARX_VOTE_NORMAL;
  assign in_vote   = (samp_r >= vote_lo) && (samp_r <= vote_lo + 5'h02);
  assign last_samp = (samp_r == vote_lo + 5'h02);
  assign bit_val   = maj3({vote_r[1:0], sync2_r});

  // receive state machine: start detect, validation, data and stop recovery
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !receiver_enable_bit)
    begin
      state_r <= UARX_IDLE;
      samp_r  <= 5'h00;
      vote_r  <= 3'h0;
      bitn_r  <= 4'h0;
      shift_r <= '0;
    end
    else if (sample_tick)
    begin
      if (in_vote)
        vote_r <= {vote_r[1:0], sync2_r};
      case (state_r)
        UARX_IDLE:
        begin
          if (line_prev_r == UARX_LINE_IDLE && sync2_r == 1'b0)
          begin
            state_r <= UARX_START;
            samp_r  <= 5'h02; // this low sample is sample one
          end
        end
        UARX_START:
        begin
          samp_r <= samp_r + 5'h01;
          if (last_samp)
          begin
            if (bit_val)
            begin
              state_r <= UARX_IDLE;
              samp_r  <= 5'h00;
            end
          end
          else if (samp_r == per_bit)
          begin
            state_r <= UARX_BITS;
            samp_r  <= 5'h01;
            bitn_r  <= 4'h0;
          end
        end
        UARX_BITS:
        begin
          samp_r <= samp_r + 5'h01;
          if (last_samp)
            shift_r <= {bit_val, shift_r[DATA_BITS-1:1]};
          if (samp_r == per_bit)
          begin
            samp_r <= 5'h01;
            if (bitn_r == 4'(DATA_BITS - 1))
              state_r <= UARX_STOP;
            bitn_r <= bitn_r + 4'h1;
          end
        end
        UARX_STOP:
        begin
          samp_r <= samp_r + 5'h01;
          if (last_samp)
          begin
            state_r <= UARX_IDLE;
            samp_r  <= 5'h00;
          end
        end
        default:
          state_r <= UARX_IDLE;
      endcase
    end
  end

  // character done at the last stop voting sample; full buffer drops it unless a read pops in the same cycle
  assign push = receiver_enable_bit && sample_tick && (state_r == UARX_STOP) && last_samp
                && (count_r != UARX_FIFO_DEPTH || pop);
  assign pop  = rx_data_rd && (count_r != 2'h0);

  // two-entry receive buffer with frame error stored per character
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !receiver_enable_bit)
    begin
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= ~wr_ptr_r;
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // buffer storage
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      mem_d_r[0]    <= '0;
      mem_d_r[1]    <= '0;
      mem_ferr_r[0] <= 1'b0;
      mem_ferr_r[1] <= 1'b0;
    end
    else if (push)
    begin
      mem_d_r[wr_ptr_r]    <= shift_r;
      mem_ferr_r[wr_ptr_r] <= ~bit_val;
    end
  end

  // head of buffer shown to software
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rx_data_location <= '0;
      frame_error_flag <= 1'b0;
      rx_complete_flag <= 1'b0;
    end
    else
    begin
      rx_data_location <= mem_d_r[rd_ptr_r];
      frame_error_flag <= mem_ferr_r[rd_ptr_r] && (count_r != 2'h0);
      rx_complete_flag <= (count_r != 2'h0);
    end
  end

endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the serial receive front end
// frames come from the line model; a queue holds the expected characters
`timescale 1ns/10ps
module tb_top;
  import uarx_pkg::*;
  logic       clk_sys = 0, rst_n = 0, sample_tick = 0, rx_data_rd = 0;
  logic       receiver_enable_bit = 0, double_speed_select = 0;
  logic [7:0] rx_data_location;
  logic       rx_complete_flag, frame_error_flag;
  wire logic  rx_line;
  int         fails = 0, checks = 0, seed = 32'h4cbbe8a2, dv = 0, bc;
  logic [8:0] q[$];
  uarx_rx uarx_rx_inst (.clk_sys, .rst_n, .rx_line, .sample_tick, .receiver_enable_bit,
    .double_speed_select, .rx_data_rd, .rx_data_location, .rx_complete_flag, .frame_error_flag);
  uarx_tx_model uarx_tx_model_inst (.clk_sys, .rx_line);
  // clock, and a sample tick every fourth cycle
  initial forever #2 clk_sys = ~clk_sys;
  always @(negedge clk_sys)
  begin
    dv = (dv + 1) % 4;
    sample_tick <= (dv == 0);
  end
  task automatic chk(string n, logic [8:0] e, logic [8:0] s);
    checks++;
    if (s !== e) $display("mismatch %s expected %h seen %h", n, e, s);
    if (s !== e) fails++;
  endtask
  task automatic end_of_test(int f);
    fails += f;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // send one random frame and queue what it should yield
  task automatic tx(int b, logic s, int sc);
    logic [7:0] d;
    d = 8'($random(seed));
    q.push_back({~s, d});
    uarx_tx_model_inst.send(d, s, b, sc);
  endtask
  // read until empty, comparing each head with the queue
  task automatic drain();
    logic [8:0] e;
    while (q.size() > 0)
    begin
      e = q.pop_front();
      for (int i = 0; i < 999 && rx_complete_flag !== 1'b1; i++) @(negedge clk_sys);
      if (rx_complete_flag !== 1'b1) end_of_test(1);
      chk("char", e, {frame_error_flag, rx_data_location});
      rx_data_rd = 1;
      @(negedge clk_sys) rx_data_rd = 0;
      repeat (3) @(negedge clk_sys);
    end
    chk("done", 9'h000, {8'h00, rx_complete_flag});
  endtask
  // main sequence, normal then double speed
  initial
  begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1;
    receiver_enable_bit = 1;
    repeat (4) @(negedge clk_sys);
    for (int m = 0; m < 2; m++)
    begin
      double_speed_select = m[0];
      bc = 64 >> m;
      tx(bc, 1, bc * 7 / 8);
      tx(bc - 1 + m, 1, bc);
      drain();
      tx(bc, 0, bc);
      uarx_tx_model_inst.hold(1, bc);
      drain();
      uarx_tx_model_inst.hold(0, bc * 5 / 16);
      uarx_tx_model_inst.hold(1, bc * 2);
      drain();
      repeat (3) tx(bc, 1, bc);
      void'(q.pop_back());
      drain();
    end
    tx(bc, 1, bc);
    chk("held", 9'h001, {8'h00, rx_complete_flag});
    receiver_enable_bit = 0;
    @(negedge clk_sys) receiver_enable_bit = 1;
    q.delete();
    repeat (3) @(negedge clk_sys);
    drain();
    end_of_test(0);
  end
endmodule
bind uarx_rx uarx_rx_sva #(.DATA_BITS(DATA_BITS)) uarx_rx_sva_inst (.clk_sys, .rst_n, .rx_line,
  .sample_tick, .receiver_enable_bit, .double_speed_select, .rx_data_rd, .rx_data_location,
  .rx_complete_flag, .frame_error_flag);

// ---- tb/uarx_rx_sva.sv ----
// port assertions for the oversampling receive front end
// bound to uarx_rx from the bench top; one clock, synchronous low reset
`timescale 1ns/10ps
module uarx_rx_sva #(
  parameter int DATA_BITS = 8
)(
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire logic                 rx_line,
  input wire logic                 sample_tick,
  input wire logic                 receiver_enable_bit,
  input wire logic                 double_speed_select,
  input wire logic                 rx_data_rd,
  input wire logic [DATA_BITS-1:0] rx_data_location,
  input wire logic                 rx_complete_flag,
  input wire logic                 frame_error_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [2:0] tk_r, rd_r, en_r;
  logic [7:0] hi_r;
  // recent ticks, reads and enable, three cycles deep
  always_ff @(posedge clk_sys)
  begin
    tk_r <= {tk_r[1:0], sample_tick};
    rd_r <= {rd_r[1:0], rx_data_rd};
    en_r <= {en_r[1:0], receiver_enable_bit && rst_n};
  end
  // ticks seen since the line was last low
  always_ff @(posedge clk_sys)
    hi_r <= (!rx_line || !rst_n) ? 8'h00 : hi_r + 8'(sample_tick && hi_r != 8'hff);
  a_flush_empty: assert property (!receiver_enable_bit |-> ##[1:2] !rx_complete_flag)
    else $error("complete flag stays up while disabled");
  a_ferr_when_empty: assert property (!rx_complete_flag [*3] |-> !frame_error_flag)
    else $error("frame error shown with empty buffer");
  a_rise_on_tick: assert property ($rose(rx_complete_flag) |-> tk_r != 3'h0)
    else $error("character pushed without a sample tick");
  a_rise_enabled: assert property ($rose(rx_complete_flag) |-> en_r[1:0] == 2'h3)
    else $error("character pushed while disabled");
  a_fall_cause: assert property ($fell(rx_complete_flag) |-> rd_r != 3'h0 || en_r != 3'h7)
    else $error("complete flag dropped without read");
  a_head_hold: assert property (tk_r == 3'h0 && rd_r == 3'h0 && en_r == 3'h7 |->
    $stable(rx_data_location) && $stable(frame_error_flag))
    else $error("buffer head changed without cause");
  a_ferr_cause: assert property ($rose(frame_error_flag) |-> tk_r != 3'h0 || rd_r != 3'h0)
    else $error("frame error rose without push or pop");
  a_idle_no_push: assert property ($rose(rx_complete_flag) |-> hi_r < 8'hb0)
    else $error("character pushed from an idle line");
endmodule

// ---- tb/uarx_tx_model.sv ----
// line model of the far transmitter: start bit, lsb first data, one stop level
// called from the bench after falling clock edges; the line idles high
`timescale 1ns/10ps
module uarx_tx_model (
  input  wire logic clk_sys,
  output logic      rx_line
);
  initial rx_line = 1'b1;
  // drive one level for a number of cycles
  task automatic hold(input logic v, input int n);
    rx_line = v;
    repeat (n) @(negedge clk_sys);
  endtask
  // one frame of bit time b cycles, stop level s held sc cycles
  task automatic send(input logic [7:0] d, input logic s, input int b, input int sc);
    hold(1'b0, b);
    for (int i = 0; i < 8; i++) hold(d[i], b);
    hold(s, sc);
    rx_line = 1'b1;
  endtask
endmodule
